// >>> hsd_pkg.sv
// constants and types for the hall signal datapath
// Function
// - range from stored setting or dynamic selection
// - low-pass filter samples before gain
// - scale filtered value by gain and compensation
// - add programmed offset after scaling
// - limit to 16 bits, feed protocol stage
// - subtract reference temperature from temperature sample
// - multiply difference by first-order coefficient
// - square difference, multiply by second-order coefficient
// - sum branches, multiply by gain
// - protocol timed in 3 us units, frame bounded
// - gain adjustable in 1/4096 steps
// - new filtered sample on each 16 kHz tick while the fifo has room
// - gain code minus 16384 over 4096
package hsd_pkg;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_GAIN   = 8'h04;
	localparam logic [7:0] ADDR_OFFSET = 8'h08;
	localparam logic [7:0] ADDR_TREF   = 8'h0c;
	localparam logic [7:0] ADDR_TC1    = 8'h10;
	localparam logic [7:0] ADDR_TC2    = 8'h14;
	localparam logic [7:0] ADDR_OUT    = 8'h18;
	localparam int CTRL_DYN_BIT = 0;
	localparam int CTRL_RNG_LSB = 1;
	localparam int CTRL_LP_LSB  = 3;
	localparam logic [14:0] GAIN_RESET   = 15'h5000;
	localparam logic [14:0] OFFSET_RESET = 15'h4000;
	localparam logic [14:0] CODE_MID     = 15'h4000;
	localparam int          FRAC_BITS    = 12;
	localparam logic [1:0]  RANGE_UNUSED = 2'h2;
	localparam logic [1:0]  RANGE_MID    = 2'h1;
	localparam logic [2:0]  LP_OFF       = 3'h7;
	localparam int CLK_HZ     = 10000000;
	localparam int CLK_NS     = 100;
	localparam int SAMPLE_HZ  = 16000;
	localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
	localparam int UNIT_NS    = 3000;
	localparam int UNIT_CYC   = (UNIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int FRAME_MAX_NS = 1000000;
	localparam logic [5:0] SYNC_TICKS = 6'h38;
	localparam logic [5:0] NIB_BASE   = 6'h0c;
	localparam logic [5:0] LOW_TICKS  = 6'h04;
	localparam logic [2:0] NIBBLES    = 3'h4;
	localparam int FIFO_DEPTH = 8;
	localparam int OUT_W      = 16;
	typedef struct packed {
		logic        dyn_en;
		logic [1:0]  range_nv;
		logic [2:0]  lp;
		logic [14:0] gain;
		logic [14:0] offset;
		logic [15:0] tref;
		logic [15:0] tc1;
		logic [15:0] tc2;
	} hsd_cfg_s;
	typedef enum logic [5:0] {
		DP_IDLE  = 6'b000001,
		DP_FILT  = 6'b000010,
		DP_TEMP  = 6'b000100,
		DP_COMP  = 6'b001000,
		DP_SCALE = 6'b010000,
		DP_PUSH  = 6'b100000
	} hsd_dp_e;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_LOAD = 3'b010,
		TX_SEND = 3'b100
	} hsd_tx_e;
endpackage

// >>> hsd_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module hsd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             pclk,     // clock
	input  wire logic             presetn,  // async reset, low
	input  wire logic [WIDTH-1:0] in_data,  // write word
	input  wire logic             in_valid, // write request
	output logic                  in_ready, // not full
	output logic      [WIDTH-1:0] out_data, // head word
	output logic                  out_valid,// not empty
	input  wire logic             out_ready // drain accepts
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;
	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_ff @(posedge pclk) begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
			if (push && !pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule

// >>> hsd_top.sv
// hall signal datapath: apb registers, compensation, limiter, output
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
module hsd_top
	import hsd_pkg::*;
(
	input  wire logic        pclk,        // 10 mhz clock
	input  wire logic        presetn,     // async reset, low
	input  wire logic        psel,        // apb select
	input  wire logic        penable,     // apb access phase
	input  wire logic        pwrite,      // apb direction
	input  wire logic [7:0]  paddr,       // apb byte address
	input  wire logic [31:0] pwdata,      // apb write data
	output logic      [31:0] prdata,      // apb read data
	output logic             pready,      // apb ready
	output logic             pslverr,     // apb error, unmapped
	input  wire logic [15:0] hall_adc,    // hall converter sample
	input  wire logic [15:0] temp_adc,    // temperature sample
	input  wire logic [1:0]  dyn_range,   // master range choice
	output logic      [1:0]  adc_range,   // range to converter
	output logic             spc_out_o,   // open-drain level
	output logic             spc_out_oe,  // high while pulling low
	output logic             sample_tick  // new sample pulse
);
	hsd_cfg_s cfg_reg;
	logic [15:0] out_last_reg;
	logic        access;
	logic        decode_ok;
	logic        fifo_in_ready;
	logic        fifo_full;
	assign fifo_full = !fifo_in_ready;
	assign access = psel && penable;
	always_comb begin
		unique case (paddr)
		ADDR_CTRL, ADDR_GAIN, ADDR_OFFSET, ADDR_TREF, ADDR_TC1,
		ADDR_TC2, ADDR_OUT:
			decode_ok = 1'b1;
		default:
			decode_ok = 1'b0;
		endcase
	end
	// register writes on the completing access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg.dyn_en   <= 1'b0;
			cfg_reg.range_nv <= RANGE_MID;
			cfg_reg.lp       <= LP_OFF;
			cfg_reg.gain     <= GAIN_RESET;
			cfg_reg.offset   <= OFFSET_RESET;
			cfg_reg.tref     <= '0;
			cfg_reg.tc1      <= '0;
			cfg_reg.tc2      <= '0;
		end else if (access && pwrite && pready) begin
			unique case (paddr)
			ADDR_CTRL: begin
				cfg_reg.dyn_en   <= pwdata[CTRL_DYN_BIT];
				cfg_reg.range_nv <= pwdata[CTRL_RNG_LSB +: 2];
				cfg_reg.lp       <= pwdata[CTRL_LP_LSB +: 3];
			end
			ADDR_GAIN:   cfg_reg.gain   <= pwdata[14:0];
			ADDR_OFFSET: cfg_reg.offset <= pwdata[14:0];
			ADDR_TREF:   cfg_reg.tref   <= pwdata[15:0];
			ADDR_TC1:    cfg_reg.tc1    <= pwdata[15:0];
			ADDR_TC2:    cfg_reg.tc2    <= pwdata[15:0];
			default: ;
			endcase
		end
	end
	// one wait state: ready in second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= access && !pready;
			pslverr <= access && !pready && !decode_ok;
			prdata  <= '0;
			if (access && !pready && !pwrite) begin
				unique case (paddr)
				ADDR_CTRL: prdata <= {26'h0, cfg_reg.lp,
					cfg_reg.range_nv, cfg_reg.dyn_en};
				ADDR_GAIN:   prdata <= {17'h0, cfg_reg.gain};
				ADDR_OFFSET: prdata <= {17'h0, cfg_reg.offset};
				ADDR_TREF:   prdata <= {16'h0, cfg_reg.tref};
				ADDR_TC1:    prdata <= {16'h0, cfg_reg.tc1};
				ADDR_TC2:    prdata <= {16'h0, cfg_reg.tc2};
				ADDR_OUT:    prdata <= {15'h0, fifo_full, out_last_reg};
				default:     prdata <= '0;
				endcase
			end
		end
	end

	// converter range, unused code folds to mid range
	logic [1:0] range_pick;
	assign range_pick = cfg_reg.dyn_en ? dyn_range : cfg_reg.range_nv;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			adc_range <= RANGE_MID;
		else
			adc_range <= (range_pick == RANGE_UNUSED) ? RANGE_MID : range_pick;
	end

	// sample rate divider
	logic [9:0] div_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg     <= '0;
			sample_tick <= 1'b0;
		end else begin
			if (div_reg == 10'(SAMPLE_CYC - 1))
				div_reg <= '0;
			else
				div_reg <= div_reg + 1'b1;
			sample_tick <= (div_reg == 10'(SAMPLE_CYC - 1));
		end
	end

	// signed working copies, Q12 where fractional
	logic signed [47:0] hall_w, temp_w, tref_w, tc1_w, tc2_w;
	logic signed [47:0] gain_w, ofs_w;
	assign hall_w = 48'(signed'(hall_adc));
	assign temp_w = 48'(signed'(temp_adc));
	assign tref_w = 48'(signed'(cfg_reg.tref));
	assign tc1_w  = 48'(signed'(cfg_reg.tc1));
	assign tc2_w  = 48'(signed'(cfg_reg.tc2));
	// gain code centred and scaled by 4096
	assign gain_w = 48'(cfg_reg.gain) - 48'(CODE_MID);
	assign ofs_w  = 48'(cfg_reg.offset) - 48'(CODE_MID);

	hsd_dp_e dp_reg;
	logic signed [47:0] filt_reg;
	logic signed [47:0] dt_reg;
	logic signed [47:0] lin_reg;
	logic signed [47:0] quad_reg;
	logic signed [47:0] fact_reg;
	logic signed [47:0] res_reg;
	logic [15:0]        lim_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dp_reg <= DP_IDLE;
		else begin
			unique case (dp_reg)
			DP_IDLE:  if (sample_tick) dp_reg <= DP_FILT;
			DP_FILT:  dp_reg <= DP_TEMP;
			DP_TEMP:  dp_reg <= DP_COMP;
			DP_COMP:  dp_reg <= DP_SCALE;
			DP_SCALE: dp_reg <= DP_PUSH;
			// stall until the fifo has room
			DP_PUSH:  if (fifo_in_ready) dp_reg <= DP_IDLE;
			endcase
		end
	end

	// first-order low-pass, unity dc gain; code 7 bypasses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			filt_reg <= '0;
		else if (dp_reg == DP_FILT) begin
			if (cfg_reg.lp == LP_OFF)
				filt_reg <= hall_w;
			else
				filt_reg <= filt_reg + ((hall_w - filt_reg)
					>>> (cfg_reg.lp + 3'h1));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dt_reg   <= '0;
			lin_reg  <= '0;
			quad_reg <= '0;
		end else begin
			if (dp_reg == DP_FILT)
				dt_reg <= temp_w - tref_w;
			if (dp_reg == DP_TEMP) begin
				lin_reg  <= (dt_reg * tc1_w) >>> FRAC_BITS;
				quad_reg <= (((dt_reg * dt_reg) >>> FRAC_BITS) * tc2_w)
					>>> FRAC_BITS;
			end
		end
	end

	// factor = gain * (1 + lin + quad), all Q12
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fact_reg <= '0;
		else if (dp_reg == DP_COMP)
			fact_reg <= (gain_w * ((48'sh1 <<< FRAC_BITS) + lin_reg
				+ quad_reg)) >>> FRAC_BITS;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			res_reg <= '0;
		else if (dp_reg == DP_SCALE)
			// scale by factor, then add offset
			res_reg <= ((filt_reg * fact_reg) >>> FRAC_BITS) + ofs_w;
	end

	always_comb begin
		if (res_reg < 48'sh0)
			lim_reg = '0;
		else if (res_reg > 48'sh0ffff)
			lim_reg = 16'hffff;
		else
			lim_reg = res_reg[15:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			out_last_reg <= '0;
		else if (dp_reg == DP_PUSH && fifo_in_ready)
			out_last_reg <= lim_reg;
	end

	logic [15:0] fifo_data;
	logic        fifo_valid;
	logic        fifo_pop;
	// 16-bit limited value to protocol stage
	hsd_fifo #(
		.WIDTH (OUT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_data   (lim_reg),
		.in_valid  (dp_reg == DP_PUSH),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// frame: sync period then four nibbles msb first
	hsd_tx_e     tx_reg;
	logic [15:0] word_reg;
	logic [4:0]  pre_reg;
	logic [5:0]  tick_reg;
	logic [2:0]  idx_reg;
	logic [5:0]  period;
	logic [3:0]  nib;
	always_comb begin
		unique case (idx_reg)
		3'h1:    nib = word_reg[15:12];
		3'h2:    nib = word_reg[11:8];
		3'h3:    nib = word_reg[7:4];
		default: nib = word_reg[3:0];
		endcase
		period = (idx_reg == 3'h0) ? SYNC_TICKS : NIB_BASE + 6'(nib);
	end
	assign fifo_pop = (tx_reg == TX_LOAD);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_reg     <= TX_IDLE;
			word_reg   <= '0;
			pre_reg    <= '0;
			tick_reg   <= '0;
			idx_reg    <= '0;
			spc_out_oe <= 1'b0;
			spc_out_o  <= 1'b0;
		end else begin
			spc_out_o <= 1'b0;
			unique case (tx_reg)
			TX_IDLE: begin
				spc_out_oe <= 1'b0;
				if (fifo_valid)
					tx_reg <= TX_LOAD;
			end
			TX_LOAD: begin
				word_reg <= fifo_data;
				pre_reg  <= '0;
				tick_reg <= '0;
				idx_reg  <= '0;
				tx_reg   <= TX_SEND;
			end
			TX_SEND: begin
				spc_out_oe <= (tick_reg < LOW_TICKS);
				if (pre_reg == 5'(UNIT_CYC - 1)) begin
					pre_reg <= '0;
					if (tick_reg == period - 6'h1) begin
						tick_reg <= '0;
						if (idx_reg == NIBBLES)
							tx_reg <= TX_IDLE;
						else
							idx_reg <= idx_reg + 3'h1;
					end else
						tick_reg <= tick_reg + 6'h1;
				end else
					pre_reg <= pre_reg + 5'h1;
			end
			endcase
		end
	end
endmodule

// >>> hsd_monitor.sv
// port checker for the hall datapath
`timescale 1ns/1ns
module hsd_monitor (
	input wire logic        pclk,        // clock
	input wire logic        presetn,     // reset, low
	input wire logic        psel,        // select
	input wire logic        penable,     // access
	input wire logic [31:0] prdata,      // read data
	input wire logic        pready,      // ready
	input wire logic        pslverr,     // error
	input wire logic [1:0]  adc_range,   // range
	input wire logic        spc_out_o,   // pin level
	input wire logic        spc_out_oe,  // pin enable
	input wire logic        sample_tick  // tick
);
	logic [9:0] gap_reg;
	logic       seen_reg;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// cycles since the last sample tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_reg  <= 10'h000;
			seen_reg <= 1'b0;
		end else begin
			gap_reg  <= sample_tick ? 10'h000 : gap_reg + 10'h001;
			seen_reg <= seen_reg | sample_tick;
		end
	end
	wait_state_a: assert property (psel && penable && !pready |=> pready)
		else $error("ready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready too long");
	data_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	err_ready_a: assert property (pslverr |-> pready && psel && penable)
		else $error("error without answer");
	tick_period_a: assert property (
		sample_tick && seen_reg |-> gap_reg == 10'd624)
		else $error("tick spacing");
	open_drain_a: assert property (!spc_out_o)
		else $error("pin driven high");
	low_pulse_a: assert property (
		$rose(spc_out_oe) |=> ##118 spc_out_oe ##1 !spc_out_oe)
		else $error("low pulse length");
	range_map_a: assert property (adc_range != 2'h2)
		else $error("unused range code");
	cover property (pslverr);
	cover property ($rose(spc_out_oe));
	cover property (sample_tick && seen_reg);
endmodule
bind hsd_top hsd_monitor u_mon (.pclk, .presetn, .psel, .penable, .prdata,
	.pready, .pslverr, .adc_range, .spc_out_o, .spc_out_oe, .sample_tick);

// >>> hsd_ecu_model.sv
// control unit model: decodes frames seen on the pulled-up line
`timescale 1ns/1ns
module hsd_ecu_model (
	input  wire logic        pclk,     // clock
	input  wire logic        presetn,  // reset, low
	input  wire logic        spc_wire, // line level
	output logic      [15:0] word,     // decoded value
	output logic             word_ok   // one-cycle valid
);
	logic [15:0] cnt;
	logic        prev;
	logic        in_frame;
	logic [1:0]  nib;
	int          t;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt = 16'h0;
			prev = 1'b1;
			in_frame = 1'b0;
			nib = 2'h0;
			word <= 16'h0;
			word_ok <= 1'b0;
		end else begin
			word_ok <= 1'b0;
			cnt = cnt + 16'h1;
			if (prev && !spc_wire) begin
				t = (int'(cnt) + 15) / 30;
				if (t == 56) begin
					in_frame = 1'b1;
					nib = 2'h0;
				end else if (in_frame) begin
					word <= {word[11:0], 4'(t - 12)};
					word_ok <= (nib == 2'h3);
					in_frame = (nib != 2'h3);
					nib = nib + 2'h1;
				end
				cnt = 16'h0;
			end
			prev = spc_wire;
		end
	end
endmodule

// >>> tb.sv
// bench: apb setup, random samples, frame and output checks
`timescale 1ns/1ns
module tb;
	import hsd_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, spc_out_o, spc_out_oe, sample_tick;
	logic [15:0] hall_adc, temp_adc, word, tr, t1, t2, exp_w;
	logic [1:0]  dyn_range, adc_range, r;
	logic [14:0] g, os;
	logic        word_ok, chk_on;
	int          fails, n_tests, seed, nfr, nwd, flt;
	localparam logic [2:0] LP_TEST = 3'h2;
	wire         spc_wire = spc_out_oe ? spc_out_o : 1'b1;
	hsd_top DUT (.*);
	hsd_ecu_model ecu (.pclk, .presetn, .spc_wire, .word, .word_ok);
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [15:0] calc(input logic [14:0] gc, oc,
		input logic [15:0] rf, c1, c2, h, tp);
		longint gq, dt, ln, qd, f, v;
		gq = longint'(gc) - 16384;
		dt = longint'($signed(tp)) - longint'($signed(rf));
		ln = (dt * longint'($signed(c1))) >>> 12;
		qd = (((dt * dt) >>> 12) * longint'($signed(c2))) >>> 12;
		f = (gq * (4096 + ln + qd)) >>> 12;
		v = ((longint'($signed(h)) * f) >>> 12) + longint'(oc) - 16384;
		return v < 0 ? 16'h0000 : v > 65535 ? 16'hffff : v[15:0];
	endfunction
	// filter stepped once per decoded word, in transmit order
	always @(posedge pclk)
		if (word_ok) begin
			nwd++;
			if (chk_on) begin
				nfr++;
				flt = flt + (($signed(hall_adc) - flt) >>> (LP_TEST + 1));
				exp_w = calc(GAIN_RESET, OFFSET_RESET, 16'h0, 16'h0, 16'h0,
					16'(flt), temp_adc);
				chk("frame", {16'h0, exp_w}, {16'h0, word});
			end
		end
	initial begin
		repeat (90000) @(posedge pclk);
		fails++;
		wrap_up;
	end
	initial begin
		seed = 32'hd98f;
		{fails, n_tests, nfr, nwd, flt, chk_on} = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata, dyn_range} = 0;
		temp_adc = 16'h0100;
		hall_adc = 16'h1234;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, ADDR_GAIN, 0);
		chk("gain", {17'h0, GAIN_RESET}, rd);
		apb(0, ADDR_OFFSET, 0);
		chk("offset", {17'h0, OFFSET_RESET}, rd);
		apb(0, 8'h1c, 0);
		chk("unmapped", 32'h1, {rd[30:0], er});
		apb(1, ADDR_CTRL, {26'h0, LP_TEST, RANGE_MID, 1'b0});
		chk_on = 1'b1;
		repeat (25000) if (nfr < 4) @(posedge pclk);
		chk("frames", 32'h1, {31'h0, nfr >= 4});
		chk_on = 1'b0;
		for (int i = 0; i < 8; i++) begin
			r = i[1:0];
			dyn_range <= r;
			apb(1, ADDR_CTRL, {26'h0, LP_OFF, i[2] ? ~r : r, i[2]});
			repeat (3) @(posedge pclk);
			chk("range", {30'h0, r == 2'h2 ? RANGE_MID : r},
				{30'h0, adc_range});
		end
		apb(1, ADDR_CTRL, {26'h0, LP_OFF, RANGE_MID, 1'b0});
		for (int i = 0; i < 5; i++) begin
			{tr, t1, t2} = 0;
			g = i ? 15'h7fff : GAIN_RESET;
			os = i ? 15'h7fff : 15'h0;
			hall_adc <= i ? 16'h7fff : 16'h0;
			temp_adc <= 16'h0;
			if (i > 1) begin
				g = 15'($random(seed));
				os = 15'($random(seed));
				tr = 16'($random(seed)) & 16'h0fff;
				t1 = 16'($random(seed)) & 16'h07ff;
				t2 = 16'($random(seed)) & 16'h07ff;
				hall_adc <= 16'($random(seed));
				temp_adc <= 16'($random(seed)) & 16'h0fff;
			end
			apb(1, ADDR_GAIN, {17'h0, g});
			apb(1, ADDR_OFFSET, {17'h0, os});
			apb(1, ADDR_TREF, {16'h0, tr});
			apb(1, ADDR_TC1, {16'h0, t1});
			apb(1, ADDR_TC2, {16'h0, t2});
			apb(0, ADDR_TC2, 0);
			chk("tc2", {16'h0, t2}, rd);
			// two frame ends after the writes flush the stalled sample
			nwd = 0;
			repeat (11000) if (nwd < 2) @(posedge pclk);
			apb(0, ADDR_OUT, 0);
			exp_w = calc(g, os, tr, t1, t2, hall_adc, temp_adc);
			chk("out", {16'h0, exp_w}, {16'h0, rd[15:0]});
		end
		wrap_up;
	end
endmodule
